// *** rtl/dhp_pkg.sv ***
// constants and types for the disk host port block
package dhp_pkg;
	// host side widths and register indices
	localparam int         DW         = 16;
	localparam logic [2:0] HREG_DATA  = 3'h0;
	localparam logic [2:0] HREG_CTRL  = 3'h1;
	localparam logic [2:0] HREG_DRVHD = 3'h6;
	localparam logic [2:0] HREG_CMD   = 3'h7;
	localparam int         DRV_BIT    = 4;
	localparam int         INTERRUPT_DISABLE_BIT_BIT   = 1;
	localparam int         SOFT_RESET_BIT_BIT   = 2;
	// avalon byte offsets
	localparam logic [5:0] A_CTRL     = 6'h00;
	localparam logic [5:0] A_ACTION   = 6'h04;
	localparam logic [5:0] A_STATUS   = 6'h08;
	localparam logic [5:0] A_DOUT     = 6'h0c;
	localparam logic [5:0] A_DIN      = 6'h10;
	localparam logic [5:0] A_INFO     = 6'h14;
	localparam logic [5:0] A_EV_STAT  = 6'h18;
	localparam logic [5:0] A_EV_CLR   = 6'h1c;
	localparam logic [5:0] A_EV_EN    = 6'h20;
	// control and action bits
	localparam int         CB_MORE    = 0;
	localparam int         CB_RDY     = 1;
	localparam int         AB_BLK     = 0;
	localparam int         AB_SUP     = 1;
	localparam int         AB_RAISE   = 2;
	// event bits
	localparam int         EV_WR      = 0;
	localparam int         EV_CMD     = 1;
	localparam int         EV_RD      = 2;
	localparam int         EV_SOFT_RESET_BIT    = 3;
	localparam int         EV_ACK     = 4;
	localparam int         EV_N       = 5;
	// reset values
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [4:0]  RST_EV    = 5'h00;
	// one host access: address and data
	typedef struct packed {
		logic [2:0]  addr;
		logic [15:0] data;
	} dhp_acc_t;
	// dma handshake states, gray from idle to req to hold
	typedef enum logic [1:0] {
		DMA_IDLE = 2'b00,
		DMA_REQ  = 2'b01,
		DMA_HOLD = 2'b11
	} dhp_dma_t;
endpackage : dhp_pkg

// *** rtl/dhp_host_port.sv ***
// device side host port with strobes, ready, dma and interrupt
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
//
// Contract
// - write strobe rise stores host data
// - drive read data while read strobe low
// - pull ready low until data port ready
// - cable select picks drive zero or one
// - interrupt needs pending, selected, enabled
// - disabled or unselected interrupt floats
// - hard or soft reset clears interrupt
// - command write or status read clears
// - each pio block start raises interrupt
// - skip first block for write commands
// - hold dma request until acknowledge
module dhp_host_port
	import dhp_pkg::*;
(
	// clock and reset
	input  wire logic          clk_in,
	input  wire logic          soft_reset_bit_in,
	// avalon slave
	input  wire logic [5:0]    avs_address_in,
	input  wire logic          avs_read_in,
	input  wire logic          avs_write_in,
	input  wire logic [31:0]   avs_writedata_in,
	input  wire logic [3:0]    avs_byteenable_in,
	output logic [31:0]        avs_readdata_out,
	output logic               avs_waitrequest_out,
	output logic               irq_out,
	// host strobes, address, cable select and dma acknowledge
	input  wire logic          host_write_strobe_n_in,
	input  wire logic          host_read_strobe_n_in,
	input  wire logic [2:0]    port_address_in,
	input  wire logic          cable_select_in,
	input  wire logic          dma_ack_n_in,
	// host data bus, three signals
	input  wire logic [DW-1:0] host_data_bus_in,
	output logic [DW-1:0]      host_data_bus_out,
	output logic               host_data_bus_oe_out,
	// open drain ready, tri-state interrupt driven high or low, driven dma request
	output logic               channel_ready_out,
	output logic               channel_ready_oe_out,
	output logic               dma_request_out,
	output logic               host_interrupt_out,
	output logic               host_interrupt_oe_out
);
	// byte enable merge for writable registers
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (wd & m);
	endfunction : merge

	// host address compare
	function automatic logic hit(input logic [2:0] a,
		input logic [2:0] idx);
		return a == idx;
	endfunction : hit

	// synchroniser stages: wr, rd, ack
	logic [2:0]     s1_reg, s2_reg, s3_reg;
	// bus slave state
	logic           wait_reg, wait_next;
	logic [31:0]    rdata_reg, rdata_next;
	// software registers
	logic [1:0]     ctrl_reg, ctrl_next;
	logic [7:0]     stat_reg, stat_next;
	logic [15:0]    dout_reg, dout_next;
	logic [15:0]    din_reg, din_next;
	logic [EV_N-1:0] ev_reg, ev_next;
	logic [EV_N-1:0] en_reg, en_next;
	logic           irq_reg, irq_next;
	// host side state
	dhp_acc_t       hold_reg, hold_next;
	logic [7:0]     cmd_reg, cmd_next;
	logic           drvsel_reg, drvsel_next;
	logic           interrupt_disable_bit_reg, interrupt_disable_bit_next;
	logic           srstb_reg, srstb_next;
	logic           drive_reg, drive_next;
	logic           rel_reg;
	logic           pend_reg, pend_next;
	logic           first_reg, first_next;
	logic [DW-1:0]  hout_reg, hout_next;
	logic           hoe_reg, hoe_next;
	logic           rdy_reg, rdy_next;
	logic           rdyoe_reg, rdyoe_next;
	logic           into_reg, into_next;
	logic           intoe_reg, intoe_next;
	dhp_dma_t       dma_reg, dma_next;
	// decoded strobes
	logic           wr_act, rd_act, ack_act, wr_rise, rd_rise;
	logic           acc, aw, sel, blk_set, set_pend, clr_pend;
	logic [31:0]    mw; // merged write word before narrowing
	logic [EV_N-1:0] ev_set;

	// strobe levels and edges, stage two onward only
	always_comb
	begin
		wr_act  = !s2_reg[0];
		rd_act  = !s2_reg[1];
		ack_act = !s2_reg[2];
		wr_rise = s2_reg[0] && !s3_reg[0];
		rd_rise = s2_reg[1] && !s3_reg[1];
		sel     = drvsel_reg == drive_reg;
		acc     = (avs_read_in || avs_write_in) && !wait_reg;
		aw      = acc && avs_write_in;
	end

	// synchroniser registers
	always_ff @(posedge clk_in)
	begin
		if (soft_reset_bit_in)
		begin
			s1_reg <= 3'h7;
			s2_reg <= 3'h7;
			s3_reg <= 3'h7;
		end
		else
		begin
			s1_reg <= {dma_ack_n_in, host_read_strobe_n_in,
				host_write_strobe_n_in};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// host access decode and interrupt logic
	always_comb
	begin
		hold_next   = hold_reg;
		cmd_next    = cmd_reg;
		drvsel_next = drvsel_reg;
		interrupt_disable_bit_next   = interrupt_disable_bit_reg;
		srstb_next  = srstb_reg;
		din_next    = din_reg;
		first_next  = first_reg;
		// latch address and data while strobe low
		if (wr_act)
		begin
			hold_next.addr = port_address_in;
			hold_next.data = host_data_bus_in;
		end
		// commit on rising edge
		if (wr_rise)
		begin
			if (hit(hold_reg.addr, HREG_DATA))
				din_next = hold_reg.data;
			else if (hit(hold_reg.addr, HREG_CTRL))
			begin
				interrupt_disable_bit_next  = hold_reg.data[INTERRUPT_DISABLE_BIT_BIT];
				srstb_next = hold_reg.data[SOFT_RESET_BIT_BIT];
			end
			else if (hit(hold_reg.addr, HREG_DRVHD))
				drvsel_next = hold_reg.data[DRV_BIT];
			else if (hit(hold_reg.addr, HREG_CMD))
			begin
				cmd_next   = hold_reg.data[7:0];
				first_next = 1'b1;
			end
		end
		// block start, suppressed first block
		blk_set = aw && avs_address_in == A_ACTION &&
			avs_writedata_in[AB_BLK] &&
			!(avs_writedata_in[AB_SUP] && first_reg);
		if (aw && avs_address_in == A_ACTION &&
			avs_writedata_in[AB_BLK])
			first_next = 1'b0;
		set_pend = blk_set || (aw && avs_address_in == A_ACTION &&
			avs_writedata_in[AB_RAISE]);
		// soft reset, command write, status read
		clr_pend = srstb_reg ||
			(wr_rise && hit(hold_reg.addr, HREG_CMD)) ||
			(rd_rise && hit(port_address_in, HREG_CMD));
		if (set_pend)
			pend_next = 1'b1;
		else if (clr_pend)
			pend_next = 1'b0;
		else
			pend_next = pend_reg;
		// drive when selected and enabled, level from pending
		into_next  = pend_reg;
		intoe_next = sel && !interrupt_disable_bit_reg;
		// read data onto bus while strobe low
		hoe_next  = rd_act && sel;
		if (hit(port_address_in, HREG_DATA))
			hout_next = dout_reg;
		else if (hit(port_address_in, HREG_CMD))
			hout_next = {8'h00, stat_reg};
		else if (hit(port_address_in, HREG_DRVHD))
			hout_next = {11'h000, drvsel_reg, 4'h0};
		else
			hout_next = RST_WORD;
		// stretch data port access until ready
		rdy_next   = ctrl_reg[CB_RDY];
		rdyoe_next = (rd_act || wr_act) && sel &&
			hit(port_address_in, HREG_DATA) && !ctrl_reg[CB_RDY];
		// cable select held from reset release
		drive_next = rel_reg ? drive_reg : cable_select_in;
	end

	// host side registers
	always_ff @(posedge clk_in)
	begin
		if (soft_reset_bit_in)
		begin
			hold_reg   <= '0;
			cmd_reg    <= 8'h00;
			drvsel_reg <= 1'b0;
			interrupt_disable_bit_reg   <= 1'b0;
			srstb_reg  <= 1'b0;
			din_reg    <= RST_WORD;
			first_reg  <= 1'b0;
			pend_reg   <= 1'b0;
			into_reg   <= 1'b0;
			intoe_reg  <= 1'b0;
			hout_reg   <= RST_WORD;
			hoe_reg    <= 1'b0;
			rdy_reg    <= 1'b0;
			rdyoe_reg  <= 1'b0;
			drive_reg  <= 1'b0;
			rel_reg    <= 1'b0;
		end
		else
		begin
			hold_reg   <= hold_next;
			cmd_reg    <= cmd_next;
			drvsel_reg <= drvsel_next;
			interrupt_disable_bit_reg   <= interrupt_disable_bit_next;
			srstb_reg  <= srstb_next;
			din_reg    <= din_next;
			first_reg  <= first_next;
			pend_reg   <= pend_next;
			into_reg   <= into_next;
			intoe_reg  <= intoe_next;
			hout_reg   <= hout_next;
			hoe_reg    <= hoe_next;
			rdy_reg    <= rdy_next;
			rdyoe_reg  <= rdyoe_next;
			drive_reg  <= drive_next;
			rel_reg    <= 1'b1;
		end
	end

	// dma request handshake
	always_comb
	begin
		case (dma_reg)
			DMA_IDLE: dma_next = (ctrl_reg[CB_MORE] && !ack_act) ?
				DMA_REQ : DMA_IDLE;
			DMA_REQ:  dma_next = ack_act ? DMA_HOLD : DMA_REQ;
			DMA_HOLD: dma_next = ack_act ? DMA_HOLD : DMA_IDLE;
			default:  dma_next = DMA_IDLE;
		endcase
	end

	// dma state register
	always_ff @(posedge clk_in)
	begin
		if (soft_reset_bit_in)
			dma_reg <= DMA_IDLE;
		else
			dma_reg <= dma_next;
	end

	// avalon slave, events and irq
	always_comb
	begin
		wait_next  = !((avs_read_in || avs_write_in) && wait_reg);
		ctrl_next  = ctrl_reg;
		stat_next  = stat_reg;
		dout_next  = dout_reg;
		en_next    = en_reg;
		rdata_next = rdata_reg;
		ev_set = '0;
		ev_set[EV_WR]   = wr_rise && hit(hold_reg.addr, HREG_DATA);
		ev_set[EV_CMD]  = wr_rise && hit(hold_reg.addr, HREG_CMD);
		ev_set[EV_RD]   = rd_rise && hit(port_address_in, HREG_DATA);
		ev_set[EV_SOFT_RESET_BIT] = srstb_next && !srstb_reg;
		ev_set[EV_ACK]  = dma_reg == DMA_REQ && ack_act;
		// set wins over clear
		ev_next = ev_reg;
		if (aw && avs_address_in == A_EV_CLR)
			ev_next = ev_reg & ~avs_writedata_in[EV_N-1:0];
		ev_next = ev_next | ev_set;
		// writes, merged word narrowed on purpose
		mw = 32'h0;
		if (aw)
		begin
			if (avs_address_in == A_CTRL)
			begin
				mw        = merge({30'h0, ctrl_reg}, avs_writedata_in,
					avs_byteenable_in);
				ctrl_next = mw[1:0];
			end
			else if (avs_address_in == A_STATUS)
			begin
				mw        = merge({24'h0, stat_reg}, avs_writedata_in,
					avs_byteenable_in);
				stat_next = mw[7:0];
			end
			else if (avs_address_in == A_DOUT)
			begin
				mw        = merge({16'h0, dout_reg}, avs_writedata_in,
					avs_byteenable_in);
				dout_next = mw[15:0];
			end
			else if (avs_address_in == A_EV_EN)
			begin
				mw      = merge({27'h0, en_reg}, avs_writedata_in,
					avs_byteenable_in);
				en_next = mw[EV_N-1:0];
			end
		end
		// read data prepared while waitrequest high
		if (avs_read_in && wait_reg)
		begin
			if (avs_address_in == A_CTRL)
				rdata_next = {30'h0, ctrl_reg};
			else if (avs_address_in == A_STATUS)
				rdata_next = {24'h0, stat_reg};
			else if (avs_address_in == A_DOUT)
				rdata_next = {16'h0, dout_reg};
			else if (avs_address_in == A_DIN)
				rdata_next = {16'h0, din_reg};
			else if (avs_address_in == A_INFO)
				rdata_next = {8'h0, cmd_reg, 8'h0, dma_reg, first_reg,
					pend_reg, srstb_reg, interrupt_disable_bit_reg, sel, drive_reg};
			else if (avs_address_in == A_EV_STAT)
				rdata_next = {27'h0, ev_reg};
			else if (avs_address_in == A_EV_EN)
				rdata_next = {27'h0, en_reg};
			else
				rdata_next = 32'h0;
		end
		irq_next = |(ev_reg & en_reg);
	end

	// slave registers
	always_ff @(posedge clk_in)
	begin
		if (soft_reset_bit_in)
		begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0;
			ctrl_reg  <= 2'h0;
			stat_reg  <= 8'h00;
			dout_reg  <= RST_WORD;
			ev_reg    <= RST_EV;
			en_reg    <= RST_EV;
			irq_reg   <= 1'b0;
		end
		else
		begin
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
			ctrl_reg  <= ctrl_next;
			stat_reg  <= stat_next;
			dout_reg  <= dout_next;
			ev_reg    <= ev_next;
			en_reg    <= en_next;
			irq_reg   <= irq_next;
		end
	end

	// outputs straight from flops, dma request decoded from dma_reg
	assign avs_readdata_out      = rdata_reg;
	assign avs_waitrequest_out   = wait_reg;
	assign irq_out               = irq_reg;
	assign host_data_bus_out     = hout_reg;
	assign host_data_bus_oe_out  = hoe_reg;
	assign channel_ready_out     = rdy_reg;
	assign channel_ready_oe_out  = rdyoe_reg;
	assign dma_request_out       = dma_reg == DMA_REQ;
	assign host_interrupt_out    = into_reg;
	assign host_interrupt_oe_out = intoe_reg;

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (soft_reset_bit_in);

	AST_WR_CAPTURE: assert property (
		wr_rise && hit(hold_reg.addr, HREG_DATA)
		|=> din_reg == $past(hold_reg.data))
		else $error("host write data not stored");
	AST_RD_DRIVE: assert property (
		rd_act && sel |=> host_data_bus_oe_out)
		else $error("read data not driven");
	AST_RD_FLOAT: assert property (
		!rd_act |=> !host_data_bus_oe_out)
		else $error("bus driven without read");
	AST_READY: assert property (
		wr_act && sel && hit(port_address_in, HREG_DATA) &&
		!ctrl_reg[CB_RDY] |=> channel_ready_oe_out && !channel_ready_out)
		else $error("ready not pulled low");
	AST_DRIVE_NUM: assert property (
		$past(soft_reset_bit_in) && !soft_reset_bit_in |=> drive_reg == $past(cable_select_in))
		else $error("drive number not from cable select");
	AST_INT_COND: assert property (
		host_interrupt_oe_out |-> $past(sel && !interrupt_disable_bit_reg))
		else $error("interrupt driven while disabled");
	AST_INT_CLR: assert property (
		clr_pend && !set_pend |=> !pend_reg ##1 !host_interrupt_out)
		else $error("interrupt not cleared");
	AST_BLK: assert property (
		blk_set |=> pend_reg ##1 host_interrupt_out)
		else $error("block start did not raise interrupt");
	AST_FIRST: assert property (
		aw && avs_address_in == A_ACTION && avs_writedata_in[AB_SUP] &&
		!avs_writedata_in[AB_RAISE] && first_reg && !pend_reg
		|=> !pend_reg)
		else $error("first write block raised interrupt");
	AST_DMA: assert property (
		dma_request_out && ack_act |=> !dma_request_out)
		else $error("dma request held past acknowledge");
	AST_DMA_HOLD: assert property (
		dma_request_out && !ack_act |=> dma_request_out)
		else $error("dma request dropped early");

	COV_WRITE: cover property (wr_rise ##[1:20] rd_rise);
	COV_INT: cover property (blk_set ##2 host_interrupt_out);
	COV_DMA: cover property (dma_request_out ##[1:20] !dma_request_out);
endmodule : dhp_host_port

// *** tb/dhp_host_model.sv ***
// host adapter model facing the disk host port
`timescale 1ns/1ps
module dhp_host_model
	import dhp_pkg::*;
(
	// clock
	input  wire logic          clk_in,
	// device pins
	input  wire logic [DW-1:0] dev_data_in,
	input  wire logic          dev_oe_in,
	input  wire logic          ready_in,
	input  wire logic          ready_oe_in,
	input  wire logic          dma_req_in,
	// host pins
	output logic               wr_n_out,
	output logic               rd_n_out,
	output logic [2:0]         addr_out,
	output logic [DW-1:0]      bus_out,
	output logic               ack_n_out,
	// observed results
	output logic [DW-1:0]      cap_out,
	output logic               cap_vld_out,
	output logic               saw_wait_out,
	output logic [7:0]         acks_out
);
	logic          h_oe;  // host drives bus
	logic [DW-1:0] h_dat; // host bus value
	logic          rdy_l; // resolved ready line
	// released bus shows inverse of last host value
	assign bus_out = h_oe ? h_dat : (dev_oe_in ? dev_data_in : ~h_dat);
	assign rdy_l   = ready_oe_in ? ready_in : 1'b1; // pull-up
	initial
	begin
		wr_n_out = 1'b1;
		rd_n_out = 1'b1;
		addr_out = 3'h0;
		h_oe = 1'b0;
		h_dat = 16'h0000;
		ack_n_out = 1'b1;
		cap_vld_out = 1'b0;
		saw_wait_out = 1'b0;
		acks_out = 8'h00;
	end
	// write cycle, long hold so the device can sync
	task automatic host_wr(input logic [2:0] a, input logic [DW-1:0] d);
		addr_out <= a;
		h_dat <= d;
		h_oe <= 1'b1;
		repeat (4) @(posedge clk_in);
		wr_n_out <= 1'b0;
		repeat (5) @(posedge clk_in);
		wr_n_out <= 1'b1;
		repeat (3) @(posedge clk_in);
		h_oe <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask : host_wr
	// read cycle, stretched while ready line low
	task automatic host_rd(input logic [2:0] a);
		int n;
		n = 0;
		addr_out <= a;
		repeat (2) @(posedge clk_in);
		rd_n_out <= 1'b0;
		repeat (5) @(posedge clk_in);
		while (!rdy_l && n < 300)
		begin
			saw_wait_out <= 1'b1;
			n++;
			@(posedge clk_in);
		end
		repeat (3) @(posedge clk_in);
		rd_n_out <= 1'b1;
		cap_out <= bus_out; // latch at strobe rise
		cap_vld_out <= 1'b1;
		@(posedge clk_in);
		cap_vld_out <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask : host_rd
	// acknowledge each request, release once it drops
	always @(posedge clk_in)
	begin
		if (dma_req_in && ack_n_out)
		begin
			ack_n_out <= 1'b0;
			acks_out <= acks_out + 8'h01;
		end
		else if (!dma_req_in)
			ack_n_out <= 1'b1;
	end
endmodule : dhp_host_model

// *** tb/disk_host_port_strobes_irq_test.sv ***
// self-checking bench for the disk host port
`timescale 1ns/1ps
module disk_host_port_strobes_irq_test;
	import dhp_pkg::*;
	logic          clk_in, soft_reset_bit_in, a_rd, a_wr, a_wait, irq, cs;
	logic [5:0]    a_adr;
	logic [31:0]   a_wd, a_rdat, d, early = 32'h0;
	logic          wr_n, rd_n, ack_n, drq, drq_q, ack_q, cap_vld, saw_wait;
	logic          bus_oe, rdy, rdy_oe, int_o, int_oe;
	logic [2:0]    hadr;
	logic [DW-1:0] bus_in, bus_out, cap;
	logic [7:0]    acks;
	logic [63:0]   aq[$]; // avalon notes: mask, value
	logic [31:0]   hq[$]; // host read notes: mask, value
	logic [63:0]   m;
	int            n_errors = 0, total_checks = 0, cyc = 0;
	dhp_host_port dhp_host_port_i (.clk_in(clk_in), .soft_reset_bit_in(soft_reset_bit_in),
		.avs_address_in(a_adr), .avs_read_in(a_rd), .avs_write_in(a_wr),
		.avs_writedata_in(a_wd), .avs_byteenable_in(4'hf),
		.avs_readdata_out(a_rdat), .avs_waitrequest_out(a_wait),
		.irq_out(irq), .host_write_strobe_n_in(wr_n),
		.host_read_strobe_n_in(rd_n), .port_address_in(hadr),
		.cable_select_in(cs), .dma_ack_n_in(ack_n),
		.host_data_bus_in(bus_in), .host_data_bus_out(bus_out),
		.host_data_bus_oe_out(bus_oe), .channel_ready_out(rdy),
		.channel_ready_oe_out(rdy_oe), .dma_request_out(drq),
		.host_interrupt_out(int_o), .host_interrupt_oe_out(int_oe));
	dhp_host_model host_model_i (.clk_in(clk_in), .dev_data_in(bus_out),
		.dev_oe_in(bus_oe), .ready_in(rdy), .ready_oe_in(rdy_oe),
		.dma_req_in(drq), .wr_n_out(wr_n), .rd_n_out(rd_n),
		.addr_out(hadr), .bus_out(bus_in), .ack_n_out(ack_n),
		.cap_out(cap), .cap_vld_out(cap_vld), .saw_wait_out(saw_wait),
		.acks_out(acks));
	// compare and count
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	task automatic ichk(input logic [1:0] e);
		check({30'h0, int_oe, int_o}, {30'h0, e});
	endtask : ichk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask : wt
	task automatic fin(input string s);
		$display("test %0s done", s);
	endtask : fin
	// one avalon access, held until waitrequest low
	task automatic av_acc(input logic [5:0] a, input logic r, input logic [31:0] w);
		a_adr <= a;
		a_rd <= r;
		a_wr <= !r;
		a_wd <= w;
		@(posedge clk_in);
		while (a_wait)
			@(posedge clk_in);
		a_rd <= 1'b0;
		a_wr <= 1'b0;
		@(posedge clk_in);
	endtask : av_acc
	task automatic av_wr(input logic [5:0] a, input logic [31:0] w);
		av_acc(a, 1'b0, w);
	endtask : av_wr
	task automatic av_rd(input logic [5:0] a, input logic [31:0] k, input logic [31:0] e);
		aq.push_back({k, e});
		av_acc(a, 1'b1, 32'h0);
	endtask : av_rd
	// clock
	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// result watcher, dma order watcher and timeout
	always @(posedge clk_in)
	begin
		cyc++;
		drq_q <= drq;
		ack_q <= ack_n;
		if (drq_q && !drq && ack_q)
			early <= early + 32'h1;
		if (a_rd && !a_wait && aq.size() > 0)
		begin
			m = aq.pop_front();
			check(a_rdat & m[63:32], m[31:0]);
		end
		if (cap_vld && hq.size() > 0)
		begin
			m = {32'h0, hq.pop_front()};
			check({16'h0, cap & m[31:16]}, {16'h0, m[15:0]});
		end
		if (cyc == 5000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	// main sequence
	initial
	begin
		soft_reset_bit_in = 1'b1;
		a_adr = 6'h00;
		a_rd = 1'b0;
		a_wr = 1'b0;
		a_wd = 32'h0;
		cs = 1'b1;
		void'($urandom(32'hb5ca));
		wt(6);
		soft_reset_bit_in <= 1'b0;
		wt(1);
		av_wr(A_CTRL, 32'h2);
		host_model_i.host_wr(HREG_DRVHD, 16'h0010);
		host_model_i.host_wr(HREG_CTRL, 16'h0000);
		av_rd(A_INFO, 32'h3, 32'h3);
		fin("select");
		d = $urandom;
		av_wr(A_EV_EN, 32'h1);
		host_model_i.host_wr(HREG_DATA, d[15:0]);
		wt(3);
		check({31'h0, irq}, 32'h1);
		av_rd(A_DIN, 32'hffff, {16'h0, d[15:0]});
		av_wr(A_EV_CLR, 32'h1);
		wt(2);
		check({31'h0, irq}, 32'h0);
		fin("write");
		d = $urandom;
		av_wr(A_DOUT, d);
		av_wr(A_CTRL, 32'h0);
		hq.push_back({16'hffff, d[15:0]});
		fork
			host_model_i.host_rd(HREG_DATA);
			begin
				wt(14);
				av_wr(A_CTRL, 32'h2);
			end
		join
		check({31'h0, saw_wait}, 32'h1);
		fin("read");
		av_wr(A_STATUS, {24'h0, d[23:16]});
		av_wr(A_ACTION, 32'h4);
		wt(3);
		ichk(2'b11);
		hq.push_back({16'h00ff, 8'h00, d[23:16]});
		host_model_i.host_rd(HREG_CMD);
		wt(3);
		ichk(2'b10);
		av_wr(A_ACTION, 32'h4);
		host_model_i.host_wr(HREG_CMD, 16'h0020);
		wt(3);
		ichk(2'b10);
		av_wr(A_ACTION, 32'h3);
		wt(3);
		ichk(2'b10);
		av_wr(A_ACTION, 32'h3);
		wt(3);
		ichk(2'b11);
		fin("interrupt");
		host_model_i.host_wr(HREG_CTRL, 16'h0002);
		wt(3);
		check({31'h0, int_oe}, 32'h0);
		host_model_i.host_wr(HREG_CTRL, 16'h0000);
		host_model_i.host_wr(HREG_DRVHD, 16'h0000);
		wt(3);
		check({31'h0, int_oe}, 32'h0);
		host_model_i.host_wr(HREG_DRVHD, 16'h0010);
		wt(3);
		ichk(2'b11);
		host_model_i.host_wr(HREG_CTRL, 16'h0004);
		wt(3);
		check({31'h0, int_o}, 32'h0);
		host_model_i.host_wr(HREG_CTRL, 16'h0000);
		fin("float");
		av_wr(A_CTRL, 32'h3);
		wt(60);
		av_wr(A_CTRL, 32'h2);
		wt(20);
		check({31'h0, acks >= 8'h02}, 32'h1);
		check(early, 32'h0);
		check({31'h0, drq}, 32'h0);
		fin("dma");
		av_rd(6'h3c, 32'hffffffff, 32'h0); // unmapped reads as zero
		av_wr(A_ACTION, 32'h4);
		wt(3);
		// grounded cable select, taken again at reset release
		cs <= 1'b0;
		soft_reset_bit_in <= 1'b1;
		wt(2);
		soft_reset_bit_in <= 1'b0;
		wt(2);
		check({31'h0, int_o}, 32'h0);
		av_rd(A_INFO, 32'h1, 32'h0);
		fin("reset");
		tally_and_finish();
	end
endmodule : disk_host_port_strobes_irq_test
